// *** hw/bctl_tuning.sv ***
module bctl_tuning #(
    parameter logic [31:0] DT_LONG_CYC = 32'(bctl_pkg::DT_LONG_CLK),
    parameter logic [31:0] CRS_B_CYC   = 32'(bctl_pkg::CRS_B_CYC),
    parameter logic [31:0] CRS_C_CYC   = 32'(bctl_pkg::CRS_C_CYC),
    parameter logic [31:0] CRS_D_CYC   = 32'(bctl_pkg::CRS_D_CYC),
    parameter logic [31:0] CPL_B_CYC   = 32'(bctl_pkg::CPL_B_CYC),
    parameter logic [31:0] CPL_C_CYC   = 32'(bctl_pkg::CPL_C_CYC)
) (
    input  wire logic        clk_sys_i,
    input  wire logic        srst_i,
    // configuration access port
    input  wire logic        cfg_wr_i,
    input  wire logic        cfg_rd_i,
    input  wire logic [7:0]  cfg_addr_i,
    input  wire logic [3:0]  cfg_be_i,
    input  wire logic [31:0] cfg_wdata_i,
    input  wire logic        cfg_from_prim_i,
    input  wire logic        rev_mode_i,
    output logic [31:0]      cfg_rdata_o,
    output logic             cfg_ack_o,
    output logic             cfg_crs_o,
    output logic             cfg_retry_o,
    // flow control
    input  wire logic        credit_freed_i,
    output logic             fc_update_o,
    // pci retry
    input  wire logic        pci_retry_i,
    input  wire logic        pci_done_i,
    output logic             retry_expired_o,
    // discard timer
    input  wire logic        brctl_dt_dis_i,
    input  wire logic        brctl_dt_fwd_i,
    input  wire logic        brctl_dt_rev_i,
    input  wire logic        dt_start_i,
    input  wire logic        dt_stop_i,
    output logic             dt_expired_o,
    // config request retry and completion timers
    input  wire logic        crs_start_i,
    input  wire logic        crs_stop_i,
    output logic             crs_expired_o,
    input  wire logic        cpl_start_i,
    input  wire logic        cpl_stop_i,
    output logic             cpl_expired_o,
    // steering
    output logic             dt_in_order_o,
    output logic [2:0]       tc_o,
    input  wire logic        link_l1_i,
    output logic             clk_gate_o
);
    if (DT_LONG_CYC == '0 || CRS_B_CYC == '0 || CRS_C_CYC == '0 ||
        CRS_D_CYC == '0 || CPL_B_CYC == '0 || CPL_C_CYC == '0) begin : g_chk
        $error("bctl_tuning: timer counts must be non-zero");
    end

    logic [31:0] tune_ff, nxt_tune;
    logic [31:0] rdata_ff, nxt_rdata;
    logic        ack_ff, nxt_ack;
    logic        crs_ff, nxt_crs;
    logic        rty_ff, nxt_rty;
    logic        credit_ff, nxt_credit;
    logic        fcu_ff, nxt_fcu;
    logic [31:0] rcnt_ff, nxt_rcnt;
    logic        rexp_ff, nxt_rexp;
    logic        gate_ff, nxt_gate;
    logic [2:0]  tc_ff, nxt_tc;
    logic [31:0] wmask;
    logic [31:0] rlimit;
    logic        locked_out;
    logic        hit_tune;
    logic        dt_on;
    logic [31:0] dt_load, crs_load, cpl_load;

    // the lock never blocks the secondary side, so it cannot lock itself out
    assign locked_out = tune_ff[bctl_pkg::LOCK_BIT]
                      & cfg_from_prim_i;
    assign hit_tune   = (cfg_addr_i == bctl_pkg::TUNE_OFF);
    assign wmask      = {{8{cfg_be_i[3]}}, {8{cfg_be_i[2]}},
                         {8{cfg_be_i[1]}}, {8{cfg_be_i[0]}}};

    always_comb begin
        unique case (tune_ff[bctl_pkg::RLIM_LSB +: 2])
            2'h0: rlimit = '0;
            2'h1: rlimit = bctl_pkg::RLIM_256;
            2'h2: rlimit = bctl_pkg::RLIM_64K;
            2'h3: rlimit = bctl_pkg::RLIM_2G;
        endcase
    end

    // retry counter; a completed transfer restarts the count
    always_comb begin
        nxt_rcnt = rcnt_ff;
        nxt_rexp = 1'b0;
        if (pci_done_i) begin
            nxt_rcnt = '0;
        end else if (pci_retry_i && rlimit != '0) begin
            if (rcnt_ff + 32'h1 >= rlimit) begin
                nxt_rcnt = '0;
                nxt_rexp = 1'b1;
            end else begin
                nxt_rcnt = rcnt_ff + 32'h1;
            end
        end
    end

    // register file; expiry set wins over a same-cycle clear
    always_comb begin
        nxt_tune  = tune_ff;
        nxt_rdata = rdata_ff;
        nxt_ack   = 1'b0;
        nxt_crs   = 1'b0;
        nxt_rty   = 1'b0;
        if ((cfg_wr_i || cfg_rd_i) && locked_out) begin
            nxt_ack = 1'b1;
            nxt_crs = ~rev_mode_i;
            nxt_rty = rev_mode_i;
            nxt_rdata = '0;
        end else if (cfg_wr_i) begin
            nxt_ack = 1'b1;
            if (hit_tune) begin
                nxt_tune = (tune_ff & ~(wmask & bctl_pkg::TUNE_RW_MASK))
                         | (cfg_wdata_i & wmask & bctl_pkg::TUNE_RW_MASK);
                nxt_tune = nxt_tune & ~(cfg_wdata_i & wmask
                         & bctl_pkg::TUNE_W1C_MASK);
            end
        end else if (cfg_rd_i) begin
            nxt_ack = 1'b1;
            // lower bits belong to other logic and read as zero here
            nxt_rdata = hit_tune ? tune_ff & (bctl_pkg::TUNE_RW_MASK
                                 | bctl_pkg::TUNE_W1C_MASK)
                                 : bctl_pkg::RSVD_RST;
        end
        if (rexp_ff) begin
            nxt_tune[bctl_pkg::RSTAT_BIT] = 1'b1;
        end
    end

    // credit updates
    always_comb begin
        nxt_credit = credit_ff;
        nxt_fcu    = 1'b0;
        if (credit_freed_i) begin
            if (tune_ff[bctl_pkg::FC_BIT] || credit_ff) begin
                nxt_fcu    = 1'b1;
                nxt_credit = 1'b0;
            end else begin
                nxt_credit = 1'b1;
            end
        end
    end

    always_comb begin
        nxt_gate = tune_ff[bctl_pkg::PWR_BIT] & link_l1_i;
        nxt_tc   = tune_ff[bctl_pkg::ISO_BIT]
                 ? tune_ff[bctl_pkg::TC_LSB +: 3]
                 : bctl_pkg::TC_DEFAULT;
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            tune_ff   <= bctl_pkg::TUNE_RST;
            rdata_ff  <= '0;
            ack_ff    <= 1'b0;
            crs_ff    <= 1'b0;
            rty_ff    <= 1'b0;
            credit_ff <= 1'b0;
            fcu_ff    <= 1'b0;
            rcnt_ff   <= '0;
            rexp_ff   <= 1'b0;
            gate_ff   <= 1'b0;
            tc_ff     <= bctl_pkg::TC_DEFAULT;
        end else begin
            tune_ff   <= nxt_tune;
            rdata_ff  <= nxt_rdata;
            ack_ff    <= nxt_ack;
            crs_ff    <= nxt_crs;
            rty_ff    <= nxt_rty;
            credit_ff <= nxt_credit;
            fcu_ff    <= nxt_fcu;
            rcnt_ff   <= nxt_rcnt;
            rexp_ff   <= nxt_rexp;
            gate_ff   <= nxt_gate;
            tc_ff     <= nxt_tc;
        end
    end

    // either disable bit turns the discard timer off
    assign dt_on = ~tune_ff[bctl_pkg::DTDIS_BIT] & ~brctl_dt_dis_i;

    always_comb begin
        if (tune_ff[bctl_pkg::DTSHORT_BIT]) begin
            dt_load = 32'(bctl_pkg::DT_SHORT_CLK);
        end else if ((rev_mode_i ? brctl_dt_rev_i : brctl_dt_fwd_i)) begin
            dt_load = 32'(bctl_pkg::DT_MID_CLK);
        end else begin
            dt_load = DT_LONG_CYC;
        end
        unique case (tune_ff[bctl_pkg::CRS_LSB +: 2])
            2'h0: crs_load = 32'(bctl_pkg::CRS_A_CYC);
            2'h1: crs_load = CRS_B_CYC;
            2'h2: crs_load = CRS_C_CYC;
            2'h3: crs_load = CRS_D_CYC;
        endcase
        unique case (tune_ff[bctl_pkg::CPL_LSB +: 2])
            2'h0: cpl_load = 32'(bctl_pkg::CPL_A_CYC);
            2'h1: cpl_load = CPL_B_CYC;
            2'h2: cpl_load = CPL_C_CYC;
            2'h3: cpl_load = '0; // zero load never starts the timer
        endcase
    end

    bctl_timer #(.CW(32)) u_dt (
        .clk_sys_i (clk_sys_i),
        .srst_i    (srst_i),
        .start_i   (dt_start_i & dt_on),
        .stop_i    (dt_stop_i | ~dt_on),
        .load_i    (dt_load),
        .busy_o    (),
        .expired_o (dt_expired_o)
    );

    bctl_timer #(.CW(32)) u_crs (
        .clk_sys_i (clk_sys_i),
        .srst_i    (srst_i),
        .start_i   (crs_start_i),
        .stop_i    (crs_stop_i),
        .load_i    (crs_load),
        .busy_o    (),
        .expired_o (crs_expired_o)
    );

    bctl_timer #(.CW(32)) u_cpl (
        .clk_sys_i (clk_sys_i),
        .srst_i    (srst_i),
        .start_i   (cpl_start_i),
        .stop_i    (cpl_stop_i),
        .load_i    (cpl_load),
        .busy_o    (),
        .expired_o (cpl_expired_o)
    );

    assign cfg_rdata_o     = rdata_ff;
    assign cfg_ack_o       = ack_ff;
    assign cfg_crs_o       = crs_ff;
    assign cfg_retry_o     = rty_ff;
    assign fc_update_o     = fcu_ff;
    assign retry_expired_o = rexp_ff;
    assign dt_in_order_o   = tune_ff[bctl_pkg::ORDER_BIT];
    assign tc_o            = tc_ff;
    assign clk_gate_o      = gate_ff;
endmodule // bctl_tuning

// *** hw/bctl_pkg.sv ***
package bctl_pkg;

    // register map
    localparam logic [7:0]  TUNE_OFF      = 8'h40;
    localparam logic [7:0]  RSVD_OFF      = 8'h44;
    localparam logic [31:0] TUNE_RST      = 32'h0920_0000;
    localparam logic [31:0] RSVD_RST      = 32'h0000_0000;
    // writable bits: 15 and 31:17; bit 16 is write-one-to-clear
    localparam logic [31:0] TUNE_RW_MASK  = 32'hFFFE_8000;
    localparam logic [31:0] TUNE_W1C_MASK = 32'h0001_0000;

    // field positions
    localparam int FC_BIT      = 15;
    localparam int RSTAT_BIT   = 16;
    localparam int RLIM_LSB    = 17;
    localparam int DTDIS_BIT   = 19;
    localparam int DTSHORT_BIT = 20;
    localparam int CRS_LSB     = 21;
    localparam int ORDER_BIT   = 23;
    localparam int CPL_LSB     = 24;
    localparam int ISO_BIT     = 26;
    localparam int TC_LSB      = 27;
    localparam int PWR_BIT     = 30;
    localparam int LOCK_BIT    = 31;

    // retry limits
    localparam logic [31:0] RLIM_256 = 32'h0000_0100;
    localparam logic [31:0] RLIM_64K = 32'h0001_0000;
    localparam logic [31:0] RLIM_2G  = 32'h8000_0000;

    localparam logic [2:0]  TC_DEFAULT = 3'h0;

    // timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int DT_SHORT_CLK  = 64;
    localparam int DT_LONG_CLK   = 32768;
    localparam int DT_MID_CLK    = 1024;
    localparam int CRS_A_US      = 25;
    localparam int CRS_B_US      = 500;
    localparam int CRS_C_MS      = 5;
    localparam int CRS_D_MS      = 25;
    localparam int CPL_A_US      = 50;
    localparam int CPL_B_MS      = 10;
    localparam int CPL_C_MS      = 50;

    localparam int CRS_A_CYC =
        (CRS_A_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CRS_B_CYC =
        (CRS_B_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CRS_C_CYC =
        (CRS_C_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CRS_D_CYC =
        (CRS_D_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CPL_A_CYC =
        (CPL_A_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CPL_B_CYC =
        (CPL_B_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CPL_C_CYC =
        (CPL_C_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        BCTL_T_IDLE = 2'b01,
        BCTL_T_RUN  = 2'b10
    } bctl_tstate_type;

endpackage

// *** hw/bctl_timer.sv ***
module bctl_timer #(
    parameter int CW = 32
) (
    input  wire logic          clk_sys_i,
    input  wire logic          srst_i,
    input  wire logic          start_i,
    input  wire logic          stop_i,
    input  wire logic [CW-1:0] load_i,
    output logic               busy_o,
    output logic               expired_o
);
    bctl_pkg::bctl_tstate_type state_ff, nxt_state;
    logic [CW-1:0]             cnt_ff, nxt_cnt;
    logic                      exp_ff, nxt_exp;

    // a start while running restarts the count from the new load
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        nxt_exp   = 1'b0;
        unique case (state_ff)
            bctl_pkg::BCTL_T_IDLE: begin
                if (start_i && load_i != '0) begin
                    nxt_state = bctl_pkg::BCTL_T_RUN;
                    nxt_cnt   = load_i;
                end
            end
            bctl_pkg::BCTL_T_RUN: begin
                if (stop_i) begin
                    nxt_state = bctl_pkg::BCTL_T_IDLE;
                end else if (start_i) begin
                    nxt_cnt = load_i;
                end else if (cnt_ff == CW'(1)) begin
                    nxt_state = bctl_pkg::BCTL_T_IDLE;
                    nxt_exp   = 1'b1;
                end else begin
                    nxt_cnt = cnt_ff - CW'(1);
                end
            end
            default: nxt_state = bctl_pkg::BCTL_T_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            state_ff <= bctl_pkg::BCTL_T_IDLE;
            cnt_ff   <= '0;
            exp_ff   <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= nxt_cnt;
            exp_ff   <= nxt_exp;
        end
    end

    assign busy_o    = (state_ff == bctl_pkg::BCTL_T_RUN);
    assign expired_o = exp_ff;
endmodule // bctl_timer

// *** tb/bctl_tuning_assertions.sv ***
module bctl_tuning_assertions (
    input wire logic        clk_sys_i,
    input wire logic        srst_i,
    input wire logic        cfg_wr_i,
    input wire logic        cfg_rd_i,
    input wire logic [7:0]  cfg_addr_i,
    input wire logic [3:0]  cfg_be_i,
    input wire logic [31:0] cfg_wdata_i,
    input wire logic        cfg_from_prim_i,
    input wire logic        rev_mode_i,
    input wire logic [31:0] cfg_rdata_o,
    input wire logic        cfg_ack_o,
    input wire logic        cfg_crs_o,
    input wire logic        cfg_retry_o,
    input wire logic        credit_freed_i,
    input wire logic        fc_update_o,
    input wire logic        pci_retry_i,
    input wire logic        pci_done_i,
    input wire logic        retry_expired_o,
    input wire logic        brctl_dt_dis_i,
    input wire logic        dt_start_i,
    input wire logic        dt_expired_o,
    input wire logic        dt_in_order_o,
    input wire logic [2:0]  tc_o,
    input wire logic        link_l1_i,
    input wire logic        clk_gate_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] sh_ff;
    logic [31:0] nxt_sh;
    logic [31:0] wm;
    logic [2:0]  tc_want;
    logic        gate_want;
    // shadow of the writable bits, so checks can tie outputs to fields
    always_comb begin
        wm = {{8{cfg_be_i[3]}}, {8{cfg_be_i[2]}}, {8{cfg_be_i[1]}}, 8'h00}
             & bctl_pkg::TUNE_RW_MASK;
        nxt_sh = sh_ff;
        if (srst_i)
            nxt_sh = bctl_pkg::TUNE_RST;
        else if (cfg_wr_i && cfg_addr_i == bctl_pkg::TUNE_OFF
                 && !(sh_ff[31] && cfg_from_prim_i))
            nxt_sh = (sh_ff & ~wm) | (cfg_wdata_i & wm);
        tc_want = sh_ff[26] ? sh_ff[29:27] : 3'h0;
        gate_want = sh_ff[30] && link_l1_i;
    end
    always_ff @(posedge clk_sys_i) sh_ff <= nxt_sh;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);

    sequence s_two_cr;
        credit_freed_i ##1 credit_freed_i;
    endsequence
    sequence s_locked_req;
        (cfg_wr_i || cfg_rd_i) && cfg_from_prim_i && sh_ff[31];
    endsequence
    sequence s_dt_short;
        dt_start_i && sh_ff[20] && !sh_ff[19] && !brctl_dt_dis_i;
    endsequence

    AST_FC_CAUSE: assert property (fc_update_o
        |-> $past(credit_freed_i))
        else $error("update without credit");
    AST_FC_ONE: assert property (credit_freed_i && sh_ff[15]
        |=> fc_update_o)
        else $error("single credit not reported");
    AST_FC_PAIR: assert property (s_two_cr
        |-> ##[0:1] fc_update_o)
        else $error("two credits without update");
    AST_EXP_CAUSE: assert property (retry_expired_o |->
        $past(pci_retry_i) && !$past(pci_done_i))
        else $error("expiry without retry");
    AST_LOCK_REFUSE: assert property (s_locked_req |=> cfg_ack_o
        && cfg_crs_o == !$past(rev_mode_i) && cfg_retry_o == $past(rev_mode_i)
        && cfg_rdata_o == 32'h0)
        else $error("locked access not refused");
    AST_OPEN_ACCEPT: assert property ((cfg_wr_i || cfg_rd_i)
        && !(cfg_from_prim_i && sh_ff[31]) |=> cfg_ack_o && !cfg_crs_o
        && !cfg_retry_o)
        else $error("open access refused");
    AST_DT_SHORT: assert property (s_dt_short
        |-> ##65 dt_expired_o)
        else $error("short discard time wrong");
    AST_ORDER: assert property (dt_in_order_o == sh_ff[23])
        else $error("order control wrong");
    AST_TC: assert property (tc_o == $past(tc_want))
        else $error("traffic class wrong");
    AST_GATE: assert property (clk_gate_o == $past(gate_want))
        else $error("clock gate wrong");
endmodule // bctl_tuning_assertions

// *** tb/bctl_far_model.sv ***
module bctl_far_model (
    input  wire logic clk_sys_i,
    input  wire logic fc_update_i,
    input  wire logic retry_expired_i,
    output logic      credit_freed_o,
    output logic      pci_retry_o,
    output logic      pci_done_o,
    output logic      link_l1_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int n_fc = 0;
    int n_exp = 0;
    initial begin
        credit_freed_o = 1'b0;
        pci_retry_o = 1'b0;
        pci_done_o = 1'b0;
        link_l1_o = 1'b0;
    end
    // outputs are one-cycle pulses, so count at every edge
    always @(posedge clk_sys_i) begin
        n_fc <= n_fc + int'(fc_update_i === 1'b1);
        n_exp <= n_exp + int'(retry_expired_i === 1'b1);
    end
    // sel 0 credits, 1 retries, 2 done; n back-to-back pulses
    task automatic burst(input int sel, input int n);
        @(posedge clk_sys_i) #1;
        credit_freed_o = (sel == 0);
        pci_retry_o = (sel == 1);
        pci_done_o = (sel == 2);
        repeat (n) @(posedge clk_sys_i);
        #1;
        {credit_freed_o, pci_retry_o, pci_done_o} = 3'h0;
        repeat (2) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic l1(input logic v);
        @(posedge clk_sys_i) #1;
        link_l1_o = v;
        repeat (2) @(posedge clk_sys_i);
        #1;
    endtask
endmodule // bctl_far_model

// *** tb/bridge_chip_tuning_control_tb.sv ***
module bridge_chip_tuning_control_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] T_LONG = 32'hC8;
    localparam logic [31:0] T_CB   = 32'h32;
    localparam logic [31:0] T_CC   = 32'h64;
    localparam logic [31:0] T_CD   = 32'h96;
    localparam logic [31:0] T_PB   = 32'h3C;
    localparam logic [31:0] T_PC   = 32'h78;
    localparam logic [7:0]  TO     = bctl_pkg::TUNE_OFF;
    logic        clk_sys_i = 1'b0;
    logic        srst_i = 1'b1;
    logic        cfg_wr_i = 1'b0, cfg_rd_i = 1'b0;
    logic        cfg_from_prim_i = 1'b0, rev_mode_i = 1'b0;
    logic [7:0]  cfg_addr_i = 8'h00;
    logic [3:0]  cfg_be_i = 4'h0;
    logic [31:0] cfg_wdata_i = 32'h0;
    logic        brctl_dt_dis_i = 1'b0, brctl_dt_fwd_i = 1'b0;
    logic        brctl_dt_rev_i = 1'b0, dt_start_i = 1'b0;
    logic        crs_start_i = 1'b0, cpl_start_i = 1'b0;
    // stops are tied: every run waits for expiry
    logic        dt_stop_i = 1'b0, crs_stop_i = 1'b0, cpl_stop_i = 1'b0;
    logic        credit_freed_i, pci_retry_i, pci_done_i, link_l1_i;
    logic [31:0] cfg_rdata_o;
    logic        cfg_ack_o, cfg_crs_o, cfg_retry_o, fc_update_o;
    logic        retry_expired_o, dt_expired_o, crs_expired_o;
    logic        cpl_expired_o, dt_in_order_o, clk_gate_o;
    logic [2:0]  tc_o;
    logic [2:0]  xp;
    int          fails = 0, n_checks = 0, cyc = 0;
    int          crs_n[4] = '{bctl_pkg::CRS_A_CYC, int'(T_CB), int'(T_CC),
                              int'(T_CD)};
    int          cpl_n[4] = '{bctl_pkg::CPL_A_CYC, int'(T_PB), int'(T_PC), 0};
    assign xp = {cpl_expired_o, crs_expired_o, dt_expired_o};

    bctl_tuning #(.DT_LONG_CYC(T_LONG), .CRS_B_CYC(T_CB), .CRS_C_CYC(T_CC),
                  .CRS_D_CYC(T_CD), .CPL_B_CYC(T_PB), .CPL_C_CYC(T_PC)
    ) i_dut (.*);
    bctl_far_model i_far (
        .clk_sys_i       (clk_sys_i),
        .fc_update_i     (fc_update_o),
        .retry_expired_i (retry_expired_o),
        .credit_freed_o  (credit_freed_i),
        .pci_retry_o     (pci_retry_i),
        .pci_done_o      (pci_done_i),
        .link_l1_o       (link_l1_i)
    );

    always #10 clk_sys_i = ~clk_sys_i;

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic acc(input logic w, input logic [7:0] a,
                       input logic [3:0] b, input logic [31:0] d);
        @(posedge clk_sys_i) #1;
        cfg_wr_i = w;
        cfg_rd_i = !w;
        cfg_addr_i = a;
        cfg_be_i = b;
        cfg_wdata_i = d;
        @(posedge clk_sys_i) #1;
        cfg_wr_i = 1'b0;
        cfg_rd_i = 1'b0;
        chk(32'(cfg_ack_o), 32'h1);
    endtask
    task automatic rdr(input logic [7:0] a, input logic [31:0] e);
        acc(1'b0, a, 4'h0, 32'h0);
        chk(cfg_rdata_o, e);
    endtask
    task automatic wrw(input logic [31:0] d);
        acc(1'b1, TO, 4'hF, d);
    endtask
    // s 0 discard, 1 config retry, 2 completion; n 0 means never expires
    // expiry shows n edges after the edge that takes the start
    task automatic tmr(input int s, input int n);
        int k;
        k = 0;
        @(posedge clk_sys_i) #1;
        {cpl_start_i, crs_start_i, dt_start_i} = 3'(1 << s);
        @(posedge clk_sys_i) #1;
        {cpl_start_i, crs_start_i, dt_start_i} = 3'h0;
        while (xp[s] !== 1'b1 && k < n + 300) begin
            @(posedge clk_sys_i) #1;
            k++;
        end
        chk(32'(k), 32'((n != 0) ? n : 300));
    endtask

    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc == 90000) begin
            fails++;
            tally_and_finish();
        end
    end

    initial begin
        repeat (4) @(posedge clk_sys_i);
        #1 srst_i = 1'b0;
        rdr(TO, bctl_pkg::TUNE_RST);
        rdr(bctl_pkg::RSVD_OFF, bctl_pkg::RSVD_RST);
        rdr(8'h80, 32'h0);
        chk(32'(tc_o), 32'h0);
        i_far.burst(0, 4);
        chk(32'(i_far.n_fc), 32'h2);
        wrw(32'h0000_8000);
        i_far.burst(0, 3);
        chk(32'(i_far.n_fc), 32'h5);
        i_far.burst(1, 300);
        chk(32'(i_far.n_exp), 32'h0);
        i_far.burst(2, 1);
        wrw(32'h0002_0000);
        i_far.burst(1, 255);
        rdr(TO, 32'h0002_0000);
        i_far.burst(1, 1);
        chk(32'(i_far.n_exp), 32'h1);
        rdr(TO, 32'h0003_0000);
        wrw(32'h0002_0000);
        rdr(TO, 32'h0003_0000);
        wrw(32'h0003_0000);
        rdr(TO, 32'h0002_0000);
        wrw(32'h0004_0000);
        i_far.burst(2, 1);
        i_far.burst(1, 65535);
        chk(32'(i_far.n_exp), 32'h1);
        i_far.burst(1, 1);
        chk(32'(i_far.n_exp), 32'h2);
        for (int i = 0; i < 4; i++) begin
            wrw(32'(i) << 21);
            tmr(1, crs_n[i]);
            wrw(32'(i) << 24);
            tmr(2, cpl_n[i]);
        end
        wrw(32'h0010_0000);
        tmr(0, bctl_pkg::DT_SHORT_CLK);
        wrw(32'h0);
        brctl_dt_fwd_i = 1'b1;
        tmr(0, bctl_pkg::DT_MID_CLK);
        brctl_dt_fwd_i = 1'b0;
        tmr(0, int'(T_LONG));
        rev_mode_i = 1'b1;
        brctl_dt_rev_i = 1'b1;
        tmr(0, bctl_pkg::DT_MID_CLK);
        // reverse mode must ignore the forward duration bit
        brctl_dt_rev_i = 1'b0;
        brctl_dt_fwd_i = 1'b1;
        tmr(0, int'(T_LONG));
        brctl_dt_fwd_i = 1'b0;
        rev_mode_i = 1'b0;
        wrw(32'h0008_0000);
        tmr(0, 0);
        wrw(32'h0);
        brctl_dt_dis_i = 1'b1;
        tmr(0, 0);
        wrw(32'hFFFF_FFFF);
        rdr(TO, bctl_pkg::TUNE_RW_MASK);
        chk(32'(tc_o), 32'h7);
        chk(32'(dt_in_order_o), 32'h1);
        i_far.l1(1'b1);
        chk(32'(clk_gate_o), 32'h1);
        acc(1'b1, TO, 4'h4, 32'h0);
        rdr(TO, 32'hFF00_8000);
        chk(32'(dt_in_order_o), 32'h0);
        cfg_from_prim_i = 1'b1;
        wrw(32'h0);
        chk(32'(cfg_crs_o), 32'h1);
        rev_mode_i = 1'b1;
        rdr(TO, 32'h0);
        chk(32'(cfg_retry_o), 32'h1);
        cfg_from_prim_i = 1'b0;
        rev_mode_i = 1'b0;
        rdr(TO, 32'hFF00_8000);
        wrw(32'h3800_0000);
        repeat (2) @(posedge clk_sys_i);
        #1;
        chk(32'(tc_o), 32'h0);
        chk(32'(clk_gate_o), 32'h0);
        tally_and_finish();
    end
endmodule // bridge_chip_tuning_control_tb

bind bctl_tuning bctl_tuning_assertions i_chk (.*);
